// ===== eth_clk_pkg.sv
/*
 * constants, types and register map of the ethernet clock-domain control
 * block. assumes a single 40 MHz core clock and a plain register port.
 */
// Overview of operation
// - writing software wakeup to clock transition control starts the clock
// - module mode must also be enabled for the module to run
// - module mode disabled plus software sleep gives power-disabled state
// - after reset the internal clock stays off until software enables it
// - at 1000 Mbps tx clock launches on rising, ctl/data on falling edge
package eth_clk_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_DOMAIN_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MODULE_CTRL  = 8'h04;
    localparam logic [7:0] OFS_STATUS       = 8'h08;
    localparam logic [7:0] OFS_OFF_SECONDS  = 8'h0c;

    // field positions
    localparam int CTL_LSB          = 0;
    localparam int CTL_MSB          = 1;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_STATE_MSB   = 3;
    localparam int STAT_CLK_ACTIVE  = 4;
    localparam int STAT_MOD_RUN     = 5;
    localparam int STAT_PWR_OFF     = 6;
    localparam int STAT_BUDGET_OVER = 7;

    // clock transition control codes
    localparam logic [1:0] CTL_NO_REQUEST       = 2'h0;
    localparam logic [1:0] CTL_SOFTWARE_SLEEP   = 2'h1;
    localparam logic [1:0] CTL_SOFTWARE_WAKEUP  = 2'h2;

    // module mode codes
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_ENABLED  = 2'h2;

    // values after reset
    localparam logic [1:0]  RST_DOMAIN_CTRL = CTL_NO_REQUEST;
    localparam logic [1:0]  RST_MODULE_MODE = MODE_DISABLED;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;

    // timing
    localparam longint CLK_PERIOD_PS    = 25000;
    localparam longint PS_PER_SECOND    = 64'h0000_00e8_d4a5_1000;
    localparam int unsigned CYCLES_PER_SECOND =
        int'(PS_PER_SECOND / CLK_PERIOD_PS);
    localparam int unsigned OFF_BUDGET_HOURS   = 200;
    localparam int unsigned SECONDS_PER_HOUR   = 3600;
    localparam logic [31:0] OFF_BUDGET_SECONDS =
        32'(OFF_BUDGET_HOURS * SECONDS_PER_HOUR);

    typedef enum logic [3:0] {
        ST_GATED     = 4'b0001,
        ST_CLOCK_ON  = 4'b0010,
        ST_RUNNING   = 4'b0100,
        ST_POWER_OFF = 4'b1000
    } domain_state_e;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    // transmit word towards the launcher
    typedef struct packed {
        logic       ctl;
        logic [3:0] data;
    } tx_word_s;

endpackage : eth_clk_pkg

// ===== rgmii_tx_launch.sv
/*
 * rgmii transmit launcher: makes the internal transmit clock phase and
 * launches clock, control and data on opposite phase edges.
 * assumes tx words come from logic on the same core clock.
 */
`timescale 1ns/1ps
module rgmii_tx_launch (
    input  wire logic                 clk_in,    // core clock
    input  wire logic                 rstn_in,   // async reset, low
    input  wire logic                 ce_in,     // clock enable
    input  wire logic                 run_in,    // internal clock running
    input  wire eth_clk_pkg::tx_word_s word_in,  // word to launch
    output logic                      txc_out,   // transmit clock
    output eth_clk_pkg::tx_word_s     word_out   // launched ctl/data
);

    typedef struct packed {
        logic                  phase;
        eth_clk_pkg::tx_word_s word;
    } launch_state_s;

    launch_state_s q;
    launch_state_s next_q;

    always_comb begin
        next_q = q;
        if (!run_in) begin
            // stopped clock sits static low
            next_q.phase = 1'b0;
            next_q.word  = '0;
        end else begin
            next_q.phase = ~q.phase;
            if (q.phase) begin
                // internal clock falls: launch ctl and data
                next_q.word = word_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else if (ce_in) begin
            q <= next_q;
        end
    end

    assign txc_out  = q.phase;
    assign word_out = q.word;

endmodule : rgmii_tx_launch

// ===== eth_clock_domain_ctrl.sv
/*
 * ethernet clock-domain and module-enable control with register port,
 * lifetime off-time accounting and the rgmii transmit launcher.
 * assumes one 40 MHz core clock; all inputs are on that clock.
 */
`timescale 1ns/1ps
module eth_clock_domain_ctrl #(
    parameter int unsigned CYCLES_PER_SECOND =
        eth_clk_pkg::CYCLES_PER_SECOND
) (
    input  wire logic                  core_clk_in,   // 40 MHz clock
    input  wire logic                  rstn_in,       // async reset, low
    input  wire logic                  ce_in,         // clock enable
    input  wire logic [7:0]            addr_in,       // register address
    input  wire logic [31:0]           wdata_in,      // write data
    input  wire logic                  wr_in,         // write strobe
    input  wire logic                  rd_in,         // read strobe
    input  wire eth_clk_pkg::tx_word_s tx_word_in,    // tx ctl/data
    output logic [31:0]                rdata_out,     // read data
    output logic                       clk_active_out, // internal clk on
    output logic                       module_run_out, // module clocked
    output logic                       power_off_out,  // power disabled
    output logic                       budget_over_out, // off time spent
    output logic                       txc_out,        // rgmii tx clock
    output logic                       txctl_out,      // rgmii tx ctl
    output logic [3:0]                 txd_out         // rgmii tx data
);

    typedef struct packed {
        logic [1:0]                 clock_transition_control;
        logic [1:0]                 module_mode;
        eth_clk_pkg::domain_state_e fsm;
        logic [31:0]                prescale;
        logic [31:0]                off_seconds;
        logic [31:0]                rdata;
        logic                       clk_active;
        logic                       module_run;
        logic                       power_off;
        logic                       budget_over;
    } ctl_state_s;

    ctl_state_s            q;
    ctl_state_s            next_q;
    eth_clk_pkg::reg_req_s req;
    eth_clk_pkg::tx_word_s launched;

    function automatic logic is_wakeup(input logic [1:0] c);
        is_wakeup = (c == eth_clk_pkg::CTL_SOFTWARE_WAKEUP);
    endfunction : is_wakeup

    function automatic logic is_power_off(input logic [1:0] c,
                                          input logic [1:0] m);
        is_power_off = (m == eth_clk_pkg::MODE_DISABLED) &&
                       (c == eth_clk_pkg::CTL_SOFTWARE_SLEEP);
    endfunction : is_power_off

    function automatic logic is_enabled(input logic [1:0] m);
        is_enabled = (m == eth_clk_pkg::MODE_ENABLED);
    endfunction : is_enabled

    // only the low control field of a written word is kept
    function automatic logic [1:0] ctl_field(input logic [31:0] w);
        ctl_field = w[eth_clk_pkg::CTL_MSB:eth_clk_pkg::CTL_LSB];
    endfunction : ctl_field

    function automatic logic [31:0] status_word(input ctl_state_s s);
        logic [31:0] w;
        w = '0;
        w[eth_clk_pkg::STAT_STATE_MSB:eth_clk_pkg::STAT_STATE_LSB] =
            s.fsm;
        w[eth_clk_pkg::STAT_CLK_ACTIVE]  = s.clk_active;
        w[eth_clk_pkg::STAT_MOD_RUN]     = s.module_run;
        w[eth_clk_pkg::STAT_PWR_OFF]     = s.power_off;
        w[eth_clk_pkg::STAT_BUDGET_OVER] = s.budget_over;
        status_word = w;
    endfunction : status_word

    assign req = '{addr:  addr_in,
                   wdata: wdata_in,
                   wr:    wr_in,
                   rd:    rd_in};

    always_comb begin
        next_q = q;

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                eth_clk_pkg::OFS_DOMAIN_CTRL: begin
                    next_q.clock_transition_control =
                        ctl_field(req.wdata);
                end
                eth_clk_pkg::OFS_MODULE_CTRL: begin
                    next_q.module_mode = ctl_field(req.wdata);
                end
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end

        // domain state follows the registered controls
        unique case (q.fsm)
            eth_clk_pkg::ST_GATED: begin
                if (is_wakeup(q.clock_transition_control)) begin
                    next_q.fsm = eth_clk_pkg::ST_CLOCK_ON;
                end else if (is_power_off(q.clock_transition_control,
                                          q.module_mode)) begin
                    next_q.fsm = eth_clk_pkg::ST_POWER_OFF;
                end
            end
            eth_clk_pkg::ST_CLOCK_ON: begin
                if (!is_wakeup(q.clock_transition_control)) begin
                    next_q.fsm = eth_clk_pkg::ST_GATED;
                end else if (is_enabled(q.module_mode)) begin
                    next_q.fsm = eth_clk_pkg::ST_RUNNING;
                end
            end
            eth_clk_pkg::ST_RUNNING: begin
                if (!is_wakeup(q.clock_transition_control)) begin
                    next_q.fsm = eth_clk_pkg::ST_GATED;
                end else if (!is_enabled(q.module_mode)) begin
                    next_q.fsm = eth_clk_pkg::ST_CLOCK_ON;
                end
            end
            eth_clk_pkg::ST_POWER_OFF: begin
                if (is_wakeup(q.clock_transition_control)) begin
                    next_q.fsm = eth_clk_pkg::ST_CLOCK_ON;
                end else if (!is_power_off(q.clock_transition_control,
                                           q.module_mode)) begin
                    next_q.fsm = eth_clk_pkg::ST_GATED;
                end
            end
            default: begin
                next_q.fsm = eth_clk_pkg::ST_GATED;
            end
        endcase

        // status flags from the new state
        next_q.clk_active = (next_q.fsm == eth_clk_pkg::ST_CLOCK_ON) ||
                            (next_q.fsm == eth_clk_pkg::ST_RUNNING);
        next_q.module_run = (next_q.fsm == eth_clk_pkg::ST_RUNNING);
        next_q.power_off  = (next_q.fsm == eth_clk_pkg::ST_POWER_OFF);

        // lifetime off-time accounting, whole seconds
        if (!q.clk_active) begin
            if (q.prescale >= CYCLES_PER_SECOND - 1) begin
                next_q.prescale = '0;
                if (q.off_seconds != 32'hffff_ffff) begin
                    next_q.off_seconds = q.off_seconds + 32'h1;
                end
            end else begin
                next_q.prescale = q.prescale + 32'h1;
            end
        end
        next_q.budget_over =
            (next_q.off_seconds >= eth_clk_pkg::OFF_BUDGET_SECONDS);

        // read data stand only in the cycle after the strobe
        next_q.rdata = eth_clk_pkg::RST_WORD;
        if (req.rd) begin
            unique case (req.addr)
                eth_clk_pkg::OFS_DOMAIN_CTRL: begin
                    next_q.rdata = {30'h0, q.clock_transition_control};
                end
                eth_clk_pkg::OFS_MODULE_CTRL: begin
                    next_q.rdata = {30'h0, q.module_mode};
                end
                eth_clk_pkg::OFS_STATUS: begin
                    next_q.rdata = status_word(q);
                end
                eth_clk_pkg::OFS_OFF_SECONDS: begin
                    next_q.rdata = q.off_seconds;
                end
                default: begin
                    next_q.rdata = eth_clk_pkg::RST_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // internal clock comes out of reset disabled
            q.clock_transition_control <= eth_clk_pkg::RST_DOMAIN_CTRL;
            q.module_mode              <= eth_clk_pkg::RST_MODULE_MODE;
            q.fsm                      <= eth_clk_pkg::ST_GATED;
            q.prescale                 <= eth_clk_pkg::RST_WORD;
            q.off_seconds              <= eth_clk_pkg::RST_WORD;
            q.rdata                    <= eth_clk_pkg::RST_WORD;
            q.clk_active               <= 1'b0;
            q.module_run               <= 1'b0;
            q.power_off                <= 1'b0;
            q.budget_over              <= 1'b0;
        end else if (ce_in) begin
            q <= next_q;
        end
    end

    // launcher runs only while the module is clocked
    rgmii_tx_launch u_launch (
        .clk_in   (core_clk_in),
        .rstn_in  (rstn_in),
        .ce_in    (ce_in),
        .run_in   (q.module_run),
        .word_in  (tx_word_in),
        .txc_out  (txc_out),
        .word_out (launched)
    );

    assign rdata_out       = q.rdata;
    assign clk_active_out  = q.clk_active;
    assign module_run_out  = q.module_run;
    assign power_off_out   = q.power_off;
    assign budget_over_out = q.budget_over;
    assign txctl_out       = launched.ctl;
    assign txd_out         = launched.data;

endmodule : eth_clock_domain_ctrl

// ===== eth_clock_domain_ctrl_monitor.sv
/*
 * port assertions for the ethernet clock-domain control block.
 * assumes binding to eth_clock_domain_ctrl and one core clock.
 */
`timescale 1ns/1ps
module eth_clk_monitor #(
    parameter int unsigned CYCLES_PER_SECOND = 4
) (
    input wire logic        core_clk_in,    // core clock
    input wire logic        rstn_in,        // reset, low
    input wire logic        ce_in,          // clock enable
    input wire logic [7:0]  addr_in,        // address
    input wire logic [31:0] wdata_in,       // write data
    input wire logic        wr_in,          // write strobe
    input wire logic        rd_in,          // read strobe
    input wire logic [31:0] rdata_out,      // read data
    input wire logic        clk_active_out, // clock on
    input wire logic        module_run_out, // module clocked
    input wire logic        power_off_out,  // power disabled
    input wire logic        txc_out,        // tx clock
    input wire logic        txctl_out,      // tx ctl
    input wire logic [3:0]  txd_out         // tx data
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    a_rdata_idle: assert property ($past(ce_in) && !$past(rd_in)
        |-> rdata_out == 32'h0) else $error("read data outside slot");
    a_wake_on: assert property (wr_in && ce_in && addr_in == 8'h00
        && wdata_in[1:0] == 2'h2 |-> ##2 clk_active_out)
        else $error("wakeup did not start clock");
    a_wake_cause: assert property ($rose(clk_active_out)
        |-> $past(wr_in, 2) && $past(addr_in, 2) == 8'h00
        && $past(wdata_in[1:0], 2) == 2'h2)
        else $error("clock started without wakeup");
    a_run_after_on: assert property ($rose(module_run_out)
        |-> $past(clk_active_out)) else $error("run before clock");
    a_off_quiet: assert property (power_off_out
        |-> !clk_active_out && !module_run_out)
        else $error("power off with clock on");
    a_off_cause: assert property ($rose(power_off_out)
        |-> !$past(clk_active_out)) else $error("power off from on");
    a_tx_idle: assert property (!module_run_out && ce_in
        |=> !txc_out && !txctl_out && txd_out == 4'h0)
        else $error("tx lines busy while idle");
    a_tx_toggle: assert property (module_run_out && ce_in
        |=> txc_out != $past(txc_out)) else $error("tx clock stuck");
    a_tx_hold: assert property ($past(module_run_out)
        && !$fell(txc_out) |-> $stable({txctl_out, txd_out}))
        else $error("tx data moved off falling clock");

    c_wake: cover property ($rose(clk_active_out));
    c_run: cover property ($rose(module_run_out));
    c_off: cover property ($rose(power_off_out));
endmodule : eth_clk_monitor

// ===== eth_clock_domain_ctrl_test.sv
/*
 * self-checking bench for eth_clock_domain_ctrl over its register port.
 * assumes the design and eth_clk_monitor are compiled before it.
 */
`timescale 1ns/1ps
module eth_clock_domain_ctrl_test;
    localparam int unsigned CPS = 4;
    logic                 clk   = 1'b0;
    logic                 rstn  = 1'b0;
    logic                 ce    = 1'b1;
    logic [7:0]           addr  = 8'h00;
    logic [31:0]          wdata = 32'h0;
    logic                 wstb  = 1'b0;
    logic                 rstb  = 1'b0;
    eth_clk_pkg::tx_word_s word = '0;
    logic [31:0]          rdata;
    logic [31:0]          secs;
    logic                 act, run, poff, bover, txc, txctl, prev;
    logic [3:0]           txd;
    int                   errors = 0;
    int                   samples_checked = 0;

    always #12.5 clk = ~clk;

    eth_clock_domain_ctrl #(.CYCLES_PER_SECOND(CPS)) dut (
        .core_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wstb), .rd_in(rstb), .tx_word_in(word),
        .rdata_out(rdata), .clk_active_out(act), .module_run_out(run),
        .power_off_out(poff), .budget_over_out(bover), .txc_out(txc),
        .txctl_out(txctl), .txd_out(txd));

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : wr

    // read data taken mid-cycle after the strobe
    task automatic peek(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : peek

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        logic [31:0] v;
        peek(a, v);
        chk(n, e, v);
    endtask : rd

    // state moves one edge after the write is taken
    task automatic flags(input logic [2:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("flags", {29'h0, e}, {29'h0, act, run, poff});
    endtask : flags

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("flags", 32'h0, {29'h0, act, run, poff});
        rd(8'h00, 32'h0, "domain");
        rd(8'h04, 32'h0, "module");
        rd(8'h08, 32'h1, "status");
        rd(8'h10, 32'h0, "unmapped");
        $display("test reset done");
        wr(8'h00, 32'hffff_fff2);
        flags(3'b100);
        rd(8'h00, 32'h2, "domain");
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h12, "status");
        $display("test wakeup done");
        @(posedge clk);
        word <= '{ctl: 1'b1, data: 4'h5};
        wr(8'h04, 32'h2);
        flags(3'b110);
        rd(8'h08, 32'h34, "status");
        peek(8'h0c, secs);
        rd(8'h0c, secs, "off seconds held");
        prev = txc;
        @(negedge clk);
        chk("txc toggle", 32'h1, {31'h0, txc ^ prev});
        chk("tx word", 32'h15, {27'h0, txctl, txd});
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        prev = txc;
        repeat (3) @(negedge clk);
        chk("txc frozen", {31'h0, prev}, {31'h0, txc});
        @(posedge clk);
        ce <= 1'b1;
        wr(8'h04, 32'h0);
        flags(3'b100);
        @(negedge clk);
        chk("tx idle", 32'h0, {26'h0, txc, txctl, txd});
        $display("test module enable done");
        wr(8'h00, 32'h1);
        flags(3'b001);
        rd(8'h08, 32'h48, "status");
        wr(8'h00, 32'h2);
        flags(3'b100);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        flags(3'b000);
        rd(8'h08, 32'h1, "status");
        $display("test sleep done");
        // twelve edges with the clock off make three whole seconds
        peek(8'h0c, secs);
        repeat (3 * CPS - 2) @(posedge clk);
        rd(8'h0c, secs + 32'h3, "off seconds");
        chk("budget", 32'h0, {31'h0, bover});
        $display("test off time done");
        close_out();
    end

    // tests need about 80 cycles, limit is 1000
    initial begin
        #(25 * 1000);
        errors++;
        close_out();
    end
endmodule : eth_clock_domain_ctrl_test

bind eth_clock_domain_ctrl eth_clk_monitor #(
    .CYCLES_PER_SECOND(CYCLES_PER_SECOND)) mon (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .clk_active_out(clk_active_out),
    .module_run_out(module_run_out), .power_off_out(power_off_out),
    .txc_out(txc_out), .txctl_out(txctl_out), .txd_out(txd_out));
